// ### design/pmt_defs.svh
`ifndef PMT_DEFS_SVH
`define PMT_DEFS_SVH

// Program store geometry.
`define PMT_ADDR_W        11
`define PMT_WORD_W        16
`define PMT_DEPTH         2048
`define PMT_RESET_VECTOR  11'h000
// Last 256-word page starts at the upper three address bits all ones.
`define PMT_LAST_PAGE_HI  3'h7
`define PMT_PAGE_LO_W     8
`define PMT_HI_W          3
// Table high byte latch reset value.
`define PMT_LATCH_RST     8'h00
// Instruction cycles taken by a table read.
`define PMT_TABLE_CYCLES  2

`endif

// ### design/pmt_pkg.sv
package pmt_pkg;

    typedef enum logic [1:0] {
        PMT_IDLE  = 2'b00,
        PMT_FETCH = 2'b01,
        PMT_DONE  = 2'b11
    } pmt_state_e;

    // Table read request from the execution core.
    typedef struct packed {
        logic       valid;
        logic       last_page;
        logic [7:0] dest_addr;
    } pmt_tab_req_s;

    // Data memory write produced by a table read.
    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] data;
    } pmt_dm_wr_s;

    // Serial pin triple: input, output, output enable.
    typedef struct packed {
        logic i;
        logic o;
        logic oe;
    } pmt_pin_s;

endpackage

// ### design/pmt_sync.sv
`timescale 1ns/1ps
`include "pmt_defs.svh"

module pmt_sync
    import pmt_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // Asynchronous level in, synchronised level out
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule

// ### design/pmt_rom.sv
`timescale 1ns/1ps
`include "pmt_defs.svh"

module pmt_rom
    import pmt_pkg::*;
#(
    parameter int ADDR_W = `PMT_ADDR_W,
    parameter int WORD_W = `PMT_WORD_W,
    parameter int DEPTH  = `PMT_DEPTH
) (
    // Clock
    input  wire logic              clk_sys,
    // Read port
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [WORD_W-1:0] rd_data,
    // Write port, driven by the programming path
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [WORD_W-1:0] wr_data
);

    // Registered read models the flash array access time of one cycle.
    logic [WORD_W-1:0] mem [DEPTH];
    logic [WORD_W-1:0] rd_q;

    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_q <= mem[rd_addr];
    end

    assign rd_data = rd_q;

endmodule

// ### design/pmt_program_memory.sv
// Functional notes
// - Program store holds 2K words of 16 bits, fetched by PC.
// - Any reset loads the program counter with address zero.
// - Table read address is high pointer bits 2:0 concatenated with low pointer, or the last page with low pointer on last-page reads.
// - Table data is addressed by a pointer separate from the PC.
// - Low byte of table word goes to the operand data memory location.
// - Upper part of the table word loads the high byte latch.
// - Latch bits without a program word bit are loaded as zero.
// - Table instructions take two instruction cycles, stalling the next.
// - High byte latch is read-only; only table reads change it.
// - Programming uses one two-way data pin and a programmer clock.
// - Debug uses one two-way data pin and an input clock pin.
`timescale 1ns/1ps
`include "pmt_defs.svh"

module pmt_program_memory
    import pmt_pkg::*;
#(
    parameter int ADDR_W = `PMT_ADDR_W,
    parameter int WORD_W = `PMT_WORD_W
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // Instruction fetch from the core
    input  wire logic              pc_load,
    input  wire logic [ADDR_W-1:0] pc_load_addr,
    input  wire logic              pc_advance,
    output logic      [ADDR_W-1:0] pc,
    output logic      [WORD_W-1:0] instr_word,
    // Table pointer registers written by the core
    input  wire logic              tbl_ptr_lo_we,
    input  wire logic              tbl_ptr_hi_we,
    input  wire logic [7:0]        tbl_ptr_wdata,
    output logic      [7:0]        tbl_ptr_lo,
    output logic      [7:0]        tbl_ptr_hi,
    // Table read request and result
    input  wire pmt_tab_req_s      tab_req,
    output logic                   tab_busy,
    output pmt_dm_wr_s             dm_wr,
    output logic      [7:0]        table_high_byte_latch,
    // Programming pins, two-way data and programmer clock
    input  wire logic              prog_serial_data_i,
    output logic                   prog_serial_data_o,
    output logic                   prog_serial_data_oe,
    input  wire logic              prog_serial_clock,
    // Debug pins, two-way data and tool clock
    input  wire logic              debug_serial_data_i,
    output logic                   debug_serial_data_o,
    output logic                   debug_serial_data_oe,
    input  wire logic              debug_serial_clock,
    // Raw programming write port into the store
    input  wire logic              prog_wr_en,
    input  wire logic [ADDR_W-1:0] prog_wr_addr,
    input  wire logic [WORD_W-1:0] prog_wr_data,
    // Synchronised serial pin levels for the programming engine
    output logic                   prog_data_sync,
    output logic                   prog_clock_sync,
    output logic                   debug_data_sync,
    output logic                   debug_clock_sync
);

    localparam int HI_W = ADDR_W - `PMT_PAGE_LO_W;

    pmt_state_e        state_q;
    pmt_state_e        state_d;
    logic [ADDR_W-1:0] pc_q;
    logic [ADDR_W-1:0] pc_d;
    logic [7:0]        ptr_lo_q;
    logic [7:0]        ptr_lo_d;
    logic [7:0]        ptr_hi_q;
    logic [7:0]        ptr_hi_d;
    logic [7:0]        latch_q;
    logic [7:0]        latch_d;
    pmt_dm_wr_s        dm_wr_q;
    pmt_dm_wr_s        dm_wr_d;
    logic [7:0]        dest_q;
    logic [7:0]        dest_d;
    logic              last_q;
    logic              last_d;
    logic [ADDR_W-1:0] tab_addr;
    logic [ADDR_W-1:0] rom_addr;
    logic [WORD_W-1:0] rom_data;

    // The store is shared; the table read borrows the port for one cycle,
    // which is why the table instruction costs an extra cycle.
    pmt_rom #(
        .ADDR_W (ADDR_W),
        .WORD_W (WORD_W)
    ) u_rom (
        .clk_sys (clk_sys),
        .rd_addr (rom_addr),
        .rd_data (rom_data),
        .wr_en   (prog_wr_en),
        .wr_addr (prog_wr_addr),
        .wr_data (prog_wr_data)
    );

    pmt_sync u_sync_pd (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .async_in (prog_serial_data_i),
        .sync_out (prog_data_sync)
    );
    pmt_sync u_sync_pc (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .async_in (prog_serial_clock),
        .sync_out (prog_clock_sync)
    );
    pmt_sync u_sync_dd (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .async_in (debug_serial_data_i),
        .sync_out (debug_data_sync)
    );
    pmt_sync u_sync_dc (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .async_in (debug_serial_clock),
        .sync_out (debug_clock_sync)
    );

    // The serial protocols are not defined here, so the pins stay released.
    assign prog_serial_data_o   = 1'b0;
    assign prog_serial_data_oe  = 1'b0;
    assign debug_serial_data_o  = 1'b0;
    assign debug_serial_data_oe = 1'b0;

    always_comb begin
        if (last_q) begin
            tab_addr = {`PMT_LAST_PAGE_HI, ptr_lo_q};
        end else begin
            tab_addr = {ptr_hi_q[HI_W-1:0], ptr_lo_q};
        end
    end

    always_comb begin
        if (state_q == PMT_FETCH) begin
            rom_addr = tab_addr;
        end else begin
            rom_addr = pc_q;
        end
    end

    always_comb begin
        state_d  = state_q;
        pc_d     = pc_q;
        ptr_lo_d = tbl_ptr_lo_we ? tbl_ptr_wdata : ptr_lo_q;
        ptr_hi_d = tbl_ptr_hi_we ? tbl_ptr_wdata : ptr_hi_q;
        latch_d  = latch_q;
        dest_d   = dest_q;
        last_d   = last_q;
        dm_wr_d  = '0;
        unique case (state_q)
            PMT_IDLE: begin
                if (tab_req.valid) begin
                    dest_d  = tab_req.dest_addr;
                    last_d  = tab_req.last_page;
                    state_d = PMT_FETCH;
                end else if (pc_load) begin
                    pc_d = pc_load_addr;
                end else if (pc_advance) begin
                    pc_d = pc_q + ADDR_W'(1);
                end
            end
            PMT_FETCH: begin
                state_d = PMT_DONE;
            end
            PMT_DONE: begin
                dm_wr_d.we   = 1'b1;
                dm_wr_d.addr = dest_q;
                dm_wr_d.data = rom_data[7:0];
                latch_d      = 8'(rom_data[WORD_W-1:8]);
                state_d      = PMT_IDLE;
            end
            default: begin
                state_d = PMT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q  <= PMT_IDLE;
            pc_q     <= `PMT_RESET_VECTOR;
            ptr_lo_q <= 8'h00;
            ptr_hi_q <= 8'h00;
            latch_q  <= `PMT_LATCH_RST;
            dest_q   <= 8'h00;
            last_q   <= 1'b0;
            dm_wr_q  <= '0;
        end else begin
            state_q  <= state_d;
            pc_q     <= pc_d;
            ptr_lo_q <= ptr_lo_d;
            ptr_hi_q <= ptr_hi_d;
            latch_q  <= latch_d;
            dest_q   <= dest_d;
            last_q   <= last_d;
            dm_wr_q  <= dm_wr_d;
        end
    end

    assign pc                    = pc_q;
    assign instr_word            = rom_data;
    assign tbl_ptr_lo            = ptr_lo_q;
    assign tbl_ptr_hi            = ptr_hi_q;
    assign tab_busy              = (state_q != PMT_IDLE);
    assign dm_wr                 = dm_wr_q;
    assign table_high_byte_latch = latch_q;

endmodule

// ### dv/pmt_chk.sv
`timescale 1ns/1ps
module pmt_chk
    import pmt_pkg::*;
#(
    parameter int ADDR_W = 11
) (
    // Clock and reset
    input wire logic              clk_sys,
    input wire logic              rst,
    // Fetch side
    input wire logic              pc_load,
    input wire logic [ADDR_W-1:0] pc_load_addr,
    input wire logic              pc_advance,
    input wire logic [ADDR_W-1:0] pc,
    // Table read side
    input wire pmt_tab_req_s      tab_req,
    input wire logic              tab_busy,
    input wire pmt_dm_wr_s        dm_wr,
    input wire logic [7:0]        table_high_byte_latch,
    // Pin enables
    input wire logic              prog_serial_data_oe,
    input wire logic              debug_serial_data_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // A taken read stalls for two busy cycles, then writes once.
    sequence s_run;
        tab_busy [*2] ##1 (!tab_busy && dm_wr.we);
    endsequence

    rst_pc_zero_a: assert property ($fell(rst) |-> pc == '0)
        else $error("pc not zero after reset");
    tab_timing_a: assert property (tab_req.valid && !tab_busy |=> s_run)
        else $error("table read timing wrong");
    dm_dest_a: assert property (dm_wr.we |->
        dm_wr.addr == $past(tab_req.dest_addr, 3))
        else $error("data write address wrong");
    dm_pulse_a: assert property (dm_wr.we |=> !dm_wr.we)
        else $error("data write longer than one cycle");
    latch_hold_a: assert property (!dm_wr.we |->
        $stable(table_high_byte_latch))
        else $error("latch changed without table read");
    busy_stall_a: assert property (tab_busy |=> $stable(pc))
        else $error("pc moved during table read");
    pc_load_a: assert property (pc_load && !tab_busy |=>
        pc == $past(pc_load_addr))
        else $error("pc load wrong");
    pc_step_a: assert property (pc_advance && !pc_load && !tab_busy
        |=> pc == $past(pc) + 1'b1)
        else $error("pc advance wrong");
    pins_off_a: assert property (
        !(prog_serial_data_oe || debug_serial_data_oe))
        else $error("serial pin driven");
endmodule

bind pmt_program_memory pmt_chk #(.ADDR_W(ADDR_W)) chk_u (
    .clk_sys              (clk_sys),
    .rst                  (rst),
    .pc_load              (pc_load),
    .pc_load_addr         (pc_load_addr),
    .pc_advance           (pc_advance),
    .pc                   (pc),
    .tab_req              (tab_req),
    .tab_busy             (tab_busy),
    .dm_wr                (dm_wr),
    .table_high_byte_latch(table_high_byte_latch),
    .prog_serial_data_oe  (prog_serial_data_oe),
    .debug_serial_data_oe (debug_serial_data_oe)
);

// ### dv/pmt_prog_model.sv
`timescale 1ns/1ps
module pmt_prog_model (
    // Clock
    input  wire logic        clk_sys,
    // Store write port
    output logic             prog_wr_en,
    output logic [10:0]      prog_wr_addr,
    output logic [15:0]      prog_wr_data,
    // Serial pins seen from the programmer and debug tool
    input  wire logic        prog_o,
    input  wire logic        prog_oe,
    input  wire logic        debug_o,
    input  wire logic        debug_oe,
    output logic             prog_data,
    output logic             prog_clock,
    output logic             debug_data,
    output logic             debug_clock
);
    // Released data lines float to the pull-up; tool clocks idle low.
    assign prog_data   = prog_oe ? prog_o : 1'b1;
    assign debug_data  = debug_oe ? debug_o : 1'b1;
    assign prog_clock  = 1'b0;
    assign debug_clock = 1'b0;

    initial begin
        prog_wr_en   = 1'b0;
        prog_wr_addr = 11'h000;
        prog_wr_data = 16'h0000;
    end

    task automatic write_word(input logic [10:0] a, input logic [15:0] d);
        @(posedge clk_sys) prog_wr_en <= 1'b1;
        prog_wr_addr <= a;
        prog_wr_data <= d;
        @(posedge clk_sys) prog_wr_en <= 1'b0;
    endtask
endmodule

// ### dv/program_memory_table_read_tb_top.sv
`timescale 1ns/1ps
module program_memory_table_read_tb_top
    import pmt_pkg::*;
;
    logic         clk_sys, rst, pc_load, pc_advance, lo_we, hi_we, tab_busy;
    logic         wr_en, p_o, p_oe, d_o, d_oe, p_i, p_ck, d_i, d_ck;
    logic [10:0]  pc_load_addr, pc, wr_addr;
    logic [15:0]  instr_word, wr_data;
    logic [7:0]   wdata, latch;
    logic [7:0]   p_lo, p_hi;
    logic         ps_d, ps_c, ds_d, ds_c;
    pmt_tab_req_s tab_req;
    pmt_dm_wr_s   dm_wr;
    int           errors, n_compared;

    pmt_program_memory dut_u (.clk_sys(clk_sys), .rst(rst),
        .pc_load(pc_load), .pc_load_addr(pc_load_addr),
        .pc_advance(pc_advance), .pc(pc), .instr_word(instr_word),
        .tbl_ptr_lo_we(lo_we), .tbl_ptr_hi_we(hi_we), .tbl_ptr_wdata(wdata),
        .tbl_ptr_lo(p_lo), .tbl_ptr_hi(p_hi), .tab_req(tab_req),
        .tab_busy(tab_busy),
        .dm_wr(dm_wr), .table_high_byte_latch(latch),
        .prog_serial_data_i(p_i), .prog_serial_data_o(p_o),
        .prog_serial_data_oe(p_oe), .prog_serial_clock(p_ck),
        .debug_serial_data_i(d_i), .debug_serial_data_o(d_o),
        .debug_serial_data_oe(d_oe), .debug_serial_clock(d_ck),
        .prog_wr_en(wr_en), .prog_wr_addr(wr_addr), .prog_wr_data(wr_data),
        .prog_data_sync(ps_d), .prog_clock_sync(ps_c),
        .debug_data_sync(ds_d), .debug_clock_sync(ds_c));

    pmt_prog_model model_u (.clk_sys(clk_sys), .prog_wr_en(wr_en),
        .prog_wr_addr(wr_addr), .prog_wr_data(wr_data), .prog_o(p_o),
        .prog_oe(p_oe), .debug_o(d_o), .debug_oe(d_oe), .prog_data(p_i),
        .prog_clock(p_ck), .debug_data(d_i), .debug_clock(d_ck));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic chk(input string what, input logic [15:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic do_reset;
        @(posedge clk_sys) rst <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk("pc", 16'h0000, {5'h00, pc});
        chk("latch", 16'h0000, {8'h00, latch});
        chk("busy", 16'h0000, {15'h0000, tab_busy});
        $display("test reset done");
    endtask

    // Pointer bytes go in on separate edges since they share one data bus.
    task automatic rd(input logic [7:0] hi, lo, dest, input logic lp,
                      input logic [15:0] w);
        int n;
        @(posedge clk_sys) lo_we <= 1'b1;
        wdata <= lo;
        @(posedge clk_sys) lo_we <= 1'b0;
        hi_we <= 1'b1;
        wdata <= hi;
        @(posedge clk_sys) hi_we <= 1'b0;
        @(posedge clk_sys) tab_req <= '{1'b1, lp, dest};
        @(posedge clk_sys) tab_req.valid <= 1'b0;
        n = 1;
        #1;
        while (dm_wr.we !== 1'b1 && n < 8) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk("edges", 16'd3, 16'(n));
        chk("dm addr", {8'h00, dest}, {8'h00, dm_wr.addr});
        chk("dm data", {8'h00, w[7:0]}, {8'h00, dm_wr.data});
        chk("latch", {8'h00, w[15:8]}, {8'h00, latch});
        chk("ptr", {hi, lo}, {p_hi, p_lo});
        @(posedge clk_sys);
        #1;
        chk("we pulse", 16'h0000, {15'h0000, dm_wr.we});
    endtask

    task automatic t_table;
        model_u.write_word(11'h306, 16'h5a1a);
        model_u.write_word(11'h705, 16'h000f);
        model_u.write_word(11'h305, 16'hffff);
        rd(8'hfb, 8'h06, 8'h42, 1'b0, 16'h5a1a);
        rd(8'h03, 8'h05, 8'h80, 1'b1, 16'h000f);
        $display("test table done");
    endtask

    // Request held high: refused while busy, retaken as the write lands.
    task automatic t_b2b;
        logic [6:0]  seen;
        logic [10:0] pc0;
        pc0 = pc;
        @(posedge clk_sys) tab_req <= '{1'b1, 1'b1, 8'h81};
        @(posedge clk_sys) pc_load <= 1'b1;
        pc_load_addr <= 11'h123;
        for (int i = 1; i < 8; i++) begin
            @(posedge clk_sys) pc_load <= 1'b0;
            if (i == 3) tab_req.valid <= 1'b0;
            #1;
            seen[i-1] = dm_wr.we;
        end
        chk("we seq", 16'h0012, {9'h000, seen});
        chk("pc held", {5'h00, pc0}, {5'h00, pc});
        $display("test b2b done");
    endtask

    // Load and advance raised together first: the load must win.
    task automatic t_fetch;
        @(posedge clk_sys) pc_load <= 1'b1;
        pc_advance <= 1'b1;
        pc_load_addr <= 11'h704;
        @(posedge clk_sys) pc_load <= 1'b0;
        @(posedge clk_sys) pc_advance <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("pc", 16'h0705, {5'h00, pc});
        chk("instr", 16'h000f, instr_word);
        chk("sync", 16'h000a, {12'h000, ps_d, ps_c, ds_d, ds_c});
        $display("test fetch done");
    endtask

    initial begin
        rst = 1'b1;
        {pc_load, pc_advance, lo_we, hi_we} = 4'h0;
        pc_load_addr = 11'h000;
        wdata = 8'h00;
        tab_req = '0;
        errors = 0;
        n_compared = 0;
        do_reset();
        t_table();
        t_b2b();
        t_fetch();
        do_reset();
        tally_and_finish();
    end

    initial begin
        repeat (3000) @(posedge clk_sys);
        errors++;
        tally_and_finish();
    end
endmodule
